// file: hw/port_state_gate.sv
// Spanning tree port gate with host port trailer tag insert and strip
//
// Function
// - Discarding port: no user forwarding, no user receive, no learning.
// - Learning port: learns addresses, passes only processor traffic.
// - Forwarding port: forwards, receives and learns normally.
// - Discarding port may still deliver override-hit frames to the processor.
// - Flush bits remove entries of ports with learning disabled.
// - Trailer tag exists only on the host port.
// - One tag byte per frame: source outbound, destination inbound.
// - Destination comes only from tag bits three to zero.
// - Tag insert and strip only while tag enable is set.
// - Destination codes: one, two, four, x111 all; zero and eight reserved.
// - Upper nibble 00nn picks queue nn; 01xx forces sending.
// - Tag bit seven set: ignore rest, use normal lookup.
// - Source codes toward host: 00, 01, 10 for ports one to three.
//
// The placing of the registers and the strobed register port are this design's own decisions.
module port_state_gate
    import gate_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic [AW-1:0] reg_addr,
    input  wire logic [DW-1:0] reg_wdata,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    output logic      [DW-1:0] reg_rdata,
    input  wire fwd_req_t      req,
    output fwd_ans_t           ans,
    output logic      [2:0]    learn_en,
    output logic      [2:0]    flush_dyn,
    output logic      [2:0]    flush_sta,
    input  wire logic          up_valid,
    input  wire beat_t         up_beat,
    input  wire logic [1:0]    up_src,
    output logic               up_ready,
    output logic               dn_valid,
    output beat_t              dn_beat,
    output logic      [31:0]   dn_fcs,
    input  wire logic          dn_ready,
    input  wire logic          hin_valid,
    input  wire beat_t         hin_beat,
    output logic               hin_ready,
    output logic               hout_valid,
    output beat_t              hout_beat,
    output host_cmd_t          hout_cmd,
    output logic      [31:0]   hout_fcs,
    input  wire logic          hout_ready
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [2:0]      tx_en;
        logic [2:0]      rx_en;
        logic [2:0]      learn_dis;
        logic            tag_en;
        logic [DW-1:0]   rdata;
        logic [2:0]      flush_dyn;
        logic [2:0]      flush_sta;
        fwd_ans_t        ans;
        logic            dn_vld;
        beat_t           dn_beat;
        logic            pend_tag;
        logic [1:0]      tag_src;
        logic            dn_first;
        logic [4:0][7:0] pipe;
        logic [2:0]      cnt;
        logic [2:0]      depth;
        logic            hout_vld;
        beat_t           hout_beat;
        host_cmd_t       hout_cmd;
        logic            hout_first;
    } state_t;

    state_t     st_ff;
    state_t     nxt_st;
    logic       dn_load;
    logic [7:0] dn_byte;
    logic       ho_load;
    logic [7:0] ho_byte;
    logic       up_take;
    logic       hin_take;
    logic [3:0] ld_x;
    logic [3:0] rx_x;
    logic [7:0] tag;
    logic [2:0] dmask;

    assign up_ready  = (!st_ff.dn_vld || dn_ready) && !st_ff.pend_tag;
    assign hin_ready = !st_ff.hout_vld || hout_ready;
    assign up_take   = up_valid && up_ready;
    assign hin_take  = hin_valid && hin_ready;
    assign ld_x      = {1'b0, st_ff.learn_dis};
    assign rx_x      = {1'b1, st_ff.rx_en};

    always_comb
    begin
        nxt_st    = st_ff;
        dn_load   = 1'b0;
        dn_byte   = 8'h00;
        ho_load   = 1'b0;
        ho_byte   = 8'h00;
        tag       = 8'h00;
        dmask     = 3'h0;

        // ------------------------------------------------------------
        // Register port
        // ------------------------------------------------------------
        nxt_st.flush_dyn = 3'h0;
        nxt_st.flush_sta = 3'h0;
        if (reg_wr)
        begin
            unique case (reg_addr)
                REG_FLUSH:
                begin
                    nxt_st.flush_dyn = reg_wdata[FLUSH_DYN_BIT] ? st_ff.learn_dis : 3'h0;
                    nxt_st.flush_sta = reg_wdata[FLUSH_STA_BIT] ? st_ff.learn_dis : 3'h0;
                end
                REG_TAG_CTRL: nxt_st.tag_en = reg_wdata[TAG_EN_BIT];
                REG_P1_CTRL, REG_P2_CTRL, REG_P3_CTRL:
                begin
                    for (int i = 0; i < NPORT; i++)
                    begin
                        if (reg_addr[5:4] == 2'(i + 1))
                        begin
                            nxt_st.tx_en[i]     = reg_wdata[TX_EN_BIT];
                            nxt_st.rx_en[i]     = reg_wdata[RX_EN_BIT];
                            nxt_st.learn_dis[i] = reg_wdata[LEARN_DIS_BIT];
                        end
                    end
                end
                default: ;
            endcase
        end
        nxt_st.rdata = 8'h00;
        if (reg_rd)
        begin
            unique case (reg_addr)
                REG_TAG_CTRL: nxt_st.rdata[TAG_EN_BIT] = st_ff.tag_en;
                REG_P1_CTRL, REG_P2_CTRL, REG_P3_CTRL:
                begin
                    for (int i = 0; i < NPORT; i++)
                    begin
                        if (reg_addr[5:4] == 2'(i + 1))
                        begin
                            nxt_st.rdata[TX_EN_BIT]     = st_ff.tx_en[i];
                            nxt_st.rdata[RX_EN_BIT]     = st_ff.rx_en[i];
                            nxt_st.rdata[LEARN_DIS_BIT] = st_ff.learn_dis[i];
                        end
                    end
                end
                REG_STATUS: nxt_st.rdata = {st_ff.hout_vld, st_ff.dn_vld, ~st_ff.learn_dis,
                                            st_ff.tx_en & st_ff.rx_en};
                default: ;
            endcase
        end

        // ------------------------------------------------------------
        // Forwarding gate
        // ------------------------------------------------------------
        nxt_st.ans.valid = req.valid;
        // user traffic needs receive and transmit enable
        nxt_st.ans.dst[2:0] = req.dst[2:0] & st_ff.tx_en & {3{rx_x[req.src]}};
        // learning ports still reach the processor
        // override hits pass even when discarding
        nxt_st.ans.dst[3] = req.dst[3] && (!ld_x[req.src] || req.override);
        nxt_st.ans.learn = req.valid && !ld_x[req.src] && (req.src != HOST_SRC);

        // ------------------------------------------------------------
        // Toward host: append source tag
        // ------------------------------------------------------------
        if (dn_ready)
        begin
            nxt_st.dn_vld = 1'b0;
        end
        if (st_ff.pend_tag && (!st_ff.dn_vld || dn_ready))
        begin
            // source code in bits one to zero
            dn_load              = 1'b1;
            dn_byte              = {TAG_SRC_PAD, st_ff.tag_src};
            nxt_st.dn_vld        = 1'b1;
            nxt_st.dn_beat       = '{data: dn_byte, last: 1'b1};
            nxt_st.pend_tag      = 1'b0;
            nxt_st.dn_first      = 1'b1;
        end
        else if (up_take)
        begin
            dn_load              = 1'b1;
            dn_byte              = up_beat.data;
            nxt_st.dn_vld        = 1'b1;
            nxt_st.tag_src       = up_src;
            nxt_st.pend_tag      = up_beat.last && st_ff.tag_en;
            nxt_st.dn_beat       = '{data: dn_byte, last: up_beat.last && !st_ff.tag_en};
            nxt_st.dn_first      = up_beat.last && !st_ff.tag_en;
        end
        if (dn_load && st_ff.dn_first)
        begin
            nxt_st.dn_first = nxt_st.dn_beat.last;
        end

        // ------------------------------------------------------------
        // From host: strip tag and checksum
        // ------------------------------------------------------------
        if (hout_ready)
        begin
            nxt_st.hout_vld = 1'b0;
        end
        if (hin_take)
        begin
            if (st_ff.cnt == 3'h0)
            begin
                // strip depth fixed at frame start
                nxt_st.depth = st_ff.tag_en ? TAG_FCS_DEPTH : FCS_DEPTH;
            end
            nxt_st.pipe = {st_ff.pipe[3:0], hin_beat.data};
            if (st_ff.cnt == nxt_st.depth)
            begin
                ho_load              = 1'b1;
                ho_byte              = st_ff.pipe[nxt_st.depth - 3'h1];
                nxt_st.hout_vld      = 1'b1;
                nxt_st.hout_beat     = '{data: ho_byte, last: hin_beat.last};
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 3'h1;
            end
            if (hin_beat.last)
            begin
                // Runts shorter than the trailer are dropped here
                nxt_st.cnt = 3'h0;
                tag        = st_ff.pipe[3];
                nxt_st.hout_cmd = '{dst: 3'h0, queue: 2'h0, queue_vld: 1'b0,
                                    force_out: 1'b0, lookup: 1'b1};
                unique case (tag[3:0])
                    TAG_DST_P1: dmask = 3'h1;
                    TAG_DST_P2: dmask = 3'h2;
                    TAG_DST_P3: dmask = 3'h4;
                    default:    dmask = (tag[2:0] == TAG_DST_ALL) ? 3'h7 : 3'h0;
                endcase
                // discarding ports never receive host frames
                dmask = dmask & ~st_ff.learn_dis;
                if (st_ff.depth == TAG_FCS_DEPTH && !tag[7] && dmask != 3'h0)
                begin
                    nxt_st.hout_cmd.dst       = dmask;
                    nxt_st.hout_cmd.lookup    = 1'b0;
                    nxt_st.hout_cmd.queue_vld = tag[7:6] == TAG_Q_SEL;
                    nxt_st.hout_cmd.queue     = tag[5:4];
                    nxt_st.hout_cmd.force_out = tag[7:6] == TAG_FORCE;
                end
            end
        end
        if (ho_load)
        begin
            nxt_st.hout_first = hin_beat.last;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            st_ff            <= '0;
            st_ff.tx_en      <= {NPORT{TX_EN_RST}};
            st_ff.rx_en      <= {NPORT{RX_EN_RST}};
            st_ff.learn_dis  <= {NPORT{LEARN_DIS_RST}};
            st_ff.tag_en     <= TAG_EN_RST;
            st_ff.dn_first   <= 1'b1;
            st_ff.hout_first <= 1'b1;
            st_ff.depth      <= FCS_DEPTH;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ----------------------------------------------------------------
    // Checksum regeneration
    // ----------------------------------------------------------------
    // fresh checksum on both paths
    fcs_crc u_fcs_dn (
        .clk   (clk),
        .rst   (rst),
        .start (st_ff.dn_first),
        .en    (dn_load),
        .data  (dn_byte),
        .fcs   (dn_fcs)
    );

    fcs_crc u_fcs_ho (
        .clk   (clk),
        .rst   (rst),
        .start (st_ff.hout_first),
        .en    (ho_load),
        .data  (ho_byte),
        .fcs   (hout_fcs)
    );

    assign reg_rdata  = st_ff.rdata;
    assign ans        = st_ff.ans;
    assign learn_en   = ~st_ff.learn_dis;
    assign flush_dyn  = st_ff.flush_dyn;
    assign flush_sta  = st_ff.flush_sta;
    assign dn_valid   = st_ff.dn_vld;
    assign dn_beat    = st_ff.dn_beat;
    assign hout_valid = st_ff.hout_vld;
    assign hout_beat  = st_ff.hout_beat;
    assign hout_cmd   = st_ff.hout_cmd;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_discard_no_user: assert property (
        req.valid && req.src != HOST_SRC && ld_x[req.src] && !rx_x[req.src]
        |=> ans.dst[2:0] == 3'h0 && !ans.learn)
        else $error("discarding port passed user traffic");
    a_learn_state_learns: assert property (
        req.valid && req.src != HOST_SRC && !ld_x[req.src] |=> ans.learn)
        else $error("learning port did not learn");
    a_forward_passes: assert property (
        req.valid && req.dst[0] && rx_x[req.src] && st_ff.tx_en[0] |=> ans.dst[0])
        else $error("forwarding path blocked");
    a_override_host: assert property (
        req.valid && req.dst[3] && req.override |=> ans.dst[3])
        else $error("override frame not delivered to host");
    a_flush_pulse: assert property (
        reg_wr && reg_addr == REG_FLUSH && reg_wdata[FLUSH_DYN_BIT]
        |=> flush_dyn == $past(st_ff.learn_dis) ##1 flush_dyn == 3'h0)
        else $error("flush pulse wrong");
    a_tag_appended: assert property (
        up_take && up_beat.last && st_ff.tag_en
        |=> !dn_beat.last ##[1:8] (dn_valid && dn_beat.last
            && dn_beat.data == {TAG_SRC_PAD, $past(up_src, 1)}))
        else $error("source tag missing");
    a_no_tag_off: assert property (
        up_take && up_beat.last && !st_ff.tag_en |=> dn_valid && dn_beat.last)
        else $error("tag inserted while disabled");
    a_lookup_no_dst: assert property (
        hout_valid && hout_beat.last && hout_cmd.lookup |-> hout_cmd.dst == 3'h0)
        else $error("lookup frame carries direct destination");
    a_read_latency: assert property (
        reg_rd && reg_addr == REG_TAG_CTRL |=> reg_rdata[TAG_EN_BIT] == $past(st_ff.tag_en))
        else $error("register read wrong");

    c_tagged_to_host: cover property (dn_valid && dn_ready && dn_beat.last && st_ff.tag_en);
    c_host_direct:    cover property (hout_valid && hout_beat.last && !hout_cmd.lookup);
    c_override_pass:  cover property (req.valid && req.override && ld_x[req.src]);

endmodule

// file: hw/gate_pkg.sv
// Shared constants, register map and carrier types of the port gate
package gate_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int          AW              = 8;
    localparam int          DW              = 8;
    localparam logic [7:0]  REG_FLUSH       = 8'h02;
    localparam logic [7:0]  REG_TAG_CTRL    = 8'h0C;
    localparam logic [7:0]  REG_P1_CTRL     = 8'h12;
    localparam logic [7:0]  REG_P2_CTRL     = 8'h22;
    localparam logic [7:0]  REG_P3_CTRL     = 8'h32;
    localparam logic [7:0]  REG_STATUS      = 8'hF0;
    localparam int          FLUSH_DYN_BIT   = 5;
    localparam int          FLUSH_STA_BIT   = 4;
    localparam int          TAG_EN_BIT      = 1;
    localparam int          TX_EN_BIT       = 2;
    localparam int          RX_EN_BIT       = 1;
    localparam int          LEARN_DIS_BIT   = 0;
    localparam logic        TX_EN_RST       = 1'b0;
    localparam logic        RX_EN_RST       = 1'b0;
    localparam logic        LEARN_DIS_RST   = 1'b1;
    localparam logic        TAG_EN_RST      = 1'b0;

    // ----------------------------------------------------------------
    // Port and tag codes
    // ----------------------------------------------------------------
    localparam int          NPORT           = 3;
    localparam logic [1:0]  HOST_SRC        = 2'h3;
    localparam logic [3:0]  TAG_DST_P1      = 4'h1;
    localparam logic [3:0]  TAG_DST_P2      = 4'h2;
    localparam logic [3:0]  TAG_DST_P3      = 4'h4;
    localparam logic [2:0]  TAG_DST_ALL     = 3'h7;
    localparam logic [1:0]  TAG_Q_SEL       = 2'h0;
    localparam logic [1:0]  TAG_FORCE       = 2'h1;
    localparam logic [5:0]  TAG_SRC_PAD     = 6'h00;
    localparam logic [2:0]  FCS_DEPTH       = 3'h4;
    localparam logic [2:0]  TAG_FCS_DEPTH   = 3'h5;
    localparam logic [31:0] CRC_INIT        = 32'hFFFFFFFF;
    localparam logic [31:0] CRC_POLY        = 32'hEDB88320;

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } beat_t;

    typedef struct packed {
        logic       valid;
        logic [1:0] src;
        logic [3:0] dst;
        logic       override;
    } fwd_req_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] dst;
        logic       learn;
    } fwd_ans_t;

    typedef struct packed {
        logic [2:0] dst;
        logic [1:0] queue;
        logic       queue_vld;
        logic       force_out;
        logic       lookup;
    } host_cmd_t;

endpackage

// file: hw/fcs_crc.sv
// Byte-serial frame check sequence generator
module fcs_crc
    import gate_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic        en,
    input  wire logic [7:0]  data,
    output logic      [31:0] fcs
);

    logic [31:0] crc_ff;
    logic [31:0] nxt_crc;

    // Start folds the seed in, so back-to-back frames need no idle cycle
    always_comb
    begin
        nxt_crc = start ? CRC_INIT : crc_ff;
        for (int i = 0; i < 8; i++)
        begin
            nxt_crc = (nxt_crc[0] ^ data[i]) ? ((nxt_crc >> 1) ^ CRC_POLY) : (nxt_crc >> 1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            crc_ff <= CRC_INIT;
        end
        else if (en)
        begin
            crc_ff <= nxt_crc;
        end
    end

    assign fcs = ~crc_ff;

endmodule

// file: dv/host_model.sv
// Processor model on the host port: sinks egress beats, sends tagged frames
module host_model
    import gate_pkg::*;
(
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  slow,
    input  wire logic  dn_valid,
    input  wire beat_t dn_beat,
    output logic       dn_ready,
    output logic       hin_valid,
    output beat_t      hin_beat,
    input  wire logic  hin_ready
);
    timeunit 1ns;
    timeprecision 1ns;

    beat_t      rx_q[$];
    logic [1:0] pace;

    initial
    begin
        hin_valid = 1'b0;
        hin_beat  = '0;
        dn_ready  = 1'b1;
        pace      = 2'h0;
    end

    // every accepted egress beat collected
    always @(posedge clk)
    begin
        if (!rst && dn_valid && dn_ready)
            rx_q.push_back(dn_beat);
        pace <= pace + 2'h1;
        // Slow mode stalls one cycle in four
        dn_ready <= !slow || (pace != 2'h3);
    end

    // payload, tag byte, four check bytes
    task automatic send_frame(input logic [7:0] b[$]);
        logic ok;
        for (int i = 0; i < b.size(); i++)
        begin
            hin_valid <= 1'b1;
            hin_beat  <= '{data: b[i], last: (i == b.size() - 1)};
            do
            begin
                @(negedge clk);
                ok = hin_ready;
                @(posedge clk);
            end
            while (!ok);
        end
        hin_valid <= 1'b0;
        // Stale byte never reused on an idle line
        hin_beat  <= '{data: ~b[b.size() - 1], last: 1'b0};
    endtask
endmodule

// file: dv/port_state_gate_tb.sv
// Self-checking bench of the port gate and host trailer tag
module port_state_gate_tb;
    import gate_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk, rst, slow, reg_wr, reg_rd, up_valid, dn_valid, dn_ready;
    logic hin_valid, hin_ready, hout_valid, up_ready, hout_ready;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [2:0] learn_en, flush_dyn, flush_sta;
    logic [1:0] up_src;
    logic [31:0] dn_fcs, hout_fcs, dn_crc, ho_crc;
    fwd_req_t   req;
    fwd_ans_t   ans;
    beat_t      up_beat, dn_beat, hin_beat, hout_beat;
    host_cmd_t  hout_cmd, out_cmd;
    beat_t      out_q[$];
    int         num_errors, checks, cycles;

    port_state_gate dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .req(req), .ans(ans),
        .learn_en(learn_en), .flush_dyn(flush_dyn), .flush_sta(flush_sta),
        .up_valid(up_valid), .up_beat(up_beat), .up_src(up_src), .up_ready(up_ready),
        .dn_valid(dn_valid), .dn_beat(dn_beat), .dn_fcs(dn_fcs), .dn_ready(dn_ready),
        .hin_valid(hin_valid), .hin_beat(hin_beat), .hin_ready(hin_ready),
        .hout_valid(hout_valid), .hout_beat(hout_beat), .hout_cmd(hout_cmd),
        .hout_fcs(hout_fcs), .hout_ready(hout_ready));

    host_model host (.clk(clk), .rst(rst), .slow(slow), .dn_valid(dn_valid),
        .dn_beat(dn_beat), .dn_ready(dn_ready), .hin_valid(hin_valid),
        .hin_beat(hin_beat), .hin_ready(hin_ready));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            stop_test();
        end
        if (!rst && dn_valid && dn_ready && dn_beat.last)
            dn_crc = dn_fcs;
        if (!rst && hout_valid && hout_ready)
        begin
            out_q.push_back(hout_beat);
            if (hout_beat.last)
                {out_cmd, ho_crc} = {hout_cmd, hout_fcs};
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    function automatic logic [31:0] crc_of(input logic [7:0] b[$]);
        logic [31:0] c = CRC_INIT;
        foreach (b[i])
            for (int k = 0; k < 8; k++)
                c = (c[0] ^ b[i][k]) ? (c >> 1) ^ CRC_POLY : c >> 1;
        return ~c;
    endfunction

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
        @(posedge clk);
    endtask

    task automatic set_ports(input logic [7:0] v1, input logic [7:0] v2, input logic [7:0] v3);
        reg_write(REG_P1_CTRL, v1);
        reg_write(REG_P2_CTRL, v2);
        reg_write(REG_P3_CTRL, v3);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        for (int p = 0; p < 3; p++)
        begin
            reg_read(REG_P1_CTRL + 8'(16 * p), d);
            check("port ctrl", d, 32'h01);
        end
        reg_read(REG_TAG_CTRL, d);
        check("tag ctrl", d, 32'h00);
        reg_read(8'h55, d);
        check("unmapped", d, 32'h00);
        check("learn enable", learn_en, 32'h0);
    endtask

    task automatic t_gate();
        logic [7:0] st[3] = '{8'h01, 8'h00, 8'h06};
        fwd_ans_t e;
        logic pass;
        for (int s = 0; s < 3; s++)
        begin
            set_ports(st[s], st[s], st[s]);
            pass = st[s][2] & st[s][1];
            @(negedge clk);
            check("learn enable", learn_en, {29'h0, {3{!st[s][0]}}});
            @(posedge clk);
            for (int k = 0; k < 6; k++)
            begin
                req <= '{valid: 1'b1, src: 2'(k / 2), dst: 4'hB, override: 1'(k % 2)};
                @(posedge clk);
                req <= '0;
                @(negedge clk);
                e = '{valid: 1'b1, dst: {!st[s][0] || k[0], 3'h3 & {3{pass}}},
                      learn: !st[s][0]};
                check("gate answer", 32'(ans), 32'(e));
                @(posedge clk);
            end
        end
    endtask

    task automatic t_flush();
        logic [7:0] d;
        set_ports(8'h06, 8'h00, 8'h01);
        reg_read(REG_STATUS, d);
        check("status", d, 32'h19);
        reg_write(REG_FLUSH, 8'h30);
        @(negedge clk);
        check("flush dyn", flush_dyn, 32'h4);
        check("flush sta", flush_sta, 32'h4);
        @(negedge clk);
        check("flush end", {flush_dyn, flush_sta}, 32'h0);
        @(posedge clk);
    endtask

    task automatic t_egress(input logic tag);
        logic ok;
        beat_t e;
        int n;
        logic [7:0] eb[$];
        reg_write(REG_TAG_CTRL, {6'h0, tag, 1'b0});
        for (int s = 0; s < 3; s++)
        begin
            for (int i = 0; i < 3; i++)
            begin
                up_valid <= 1'b1;
                up_src   <= 2'(s);
                up_beat  <= '{data: 8'h40 + 8'(16 * s + i), last: (i == 2)};
                do
                begin
                    @(negedge clk);
                    ok = up_ready;
                    @(posedge clk);
                end
                while (!ok);
            end
            up_valid <= 1'b0;
            up_beat  <= '{data: ~(8'h42 + 8'(16 * s)), last: 1'b0};
            n = 3 + int'(tag);
            for (int w = 0; w < 60 && host.rx_q.size() < n; w++)
                @(posedge clk);
            check("egress count", host.rx_q.size(), n);
            for (int i = 0; i < n; i++)
            begin
                e = (i < 3) ? beat_t'{data: 8'h40 + 8'(16 * s + i), last: (i == 2) && !tag}
                            : beat_t'{data: {6'h0, 2'(s)}, last: 1'b1};
                check("egress beat", 32'(host.rx_q[i]), 32'(e));
                eb.push_back(e.data);
            end
            check("egress fcs", dn_crc, crc_of(eb));
            eb.delete();
            host.rx_q.delete();
        end
    endtask

    function automatic host_cmd_t exp_cmd(input logic [7:0] t, input logic [2:0] fwd);
        host_cmd_t e;
        e = '0;
        if (!t[7])
        begin
            case (t[3:0])
                4'h1: e.dst = 3'h1;
                4'h2: e.dst = 3'h2;
                4'h4: e.dst = 3'h4;
                4'h7, 4'hF: e.dst = 3'h7;
                default: e.dst = 3'h0;
            endcase
            e.dst       = e.dst & fwd;
            if (e.dst != 3'h0)
            begin
                e.queue_vld = !t[6];
                e.queue     = t[5:4];
                e.force_out = t[6];
            end
        end
        e.lookup = (e.dst == 3'h0);
        return e;
    endfunction

    // host sends only to ports it has opened
    task automatic t_ingress(input logic [7:0] t, input logic tag, input logic [2:0] fwd);
        logic [7:0] f[$] = '{8'h11, 8'h22, 8'h33, t, 8'hA5, 8'h5A, 8'hC3, 8'h3C};
        int n;
        n = tag ? 3 : 4;
        host.send_frame(f);
        for (int w = 0; w < 60 && out_q.size() < n; w++)
            @(posedge clk);
        check("ingress count", out_q.size(), n);
        for (int i = 0; i < n; i++)
            check("ingress beat", 32'(out_q[i]), {23'h0, f[i], i == n - 1});
        check("ingress fcs", ho_crc, crc_of(f[0:n-1]));
        if (tag)
            check("host command", 32'(out_cmd), 32'(exp_cmd(t, fwd)));
        out_q.delete();
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        logic [7:0] tags[14] = '{8'h01, 8'h02, 8'h04, 8'h07, 8'h0F, 8'h00, 8'h08,
                                 8'h13, 8'h22, 8'h34, 8'h41, 8'h47, 8'h80, 8'h8F};
        rst = 1'b1;
        slow = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        req = '0;
        {up_valid, up_src, up_beat} = '0;
        hout_ready = 1'b1;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset();
        t_gate();
        t_flush();
        slow <= 1'b1;
        t_egress(1'b1);
        slow <= 1'b0;
        t_egress(1'b0);
        set_ports(8'h06, 8'h06, 8'h06);
        reg_write(REG_TAG_CTRL, 8'h02);
        foreach (tags[i])
            t_ingress(tags[i], 1'b1, 3'h7);
        reg_write(REG_P3_CTRL, 8'h01);
        t_ingress(8'h07, 1'b1, 3'h3);
        t_ingress(8'h04, 1'b1, 3'h3);
        reg_write(REG_TAG_CTRL, 8'h00);
        t_ingress(8'h01, 1'b0, 3'h3);
        stop_test();
    end
endmodule
